// ==== design/rrc_pkg.sv ====
/*
 * Constants and carrier types for the receive recombiner configuration bank.
 * Assumes a 16-bit register port with word addresses and one core clock.
 */
package rrc_pkg;
    // Register word addresses and counts.
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] OFS_LINK_PAIR = 10'h201;
    localparam int NUM_LINK_PAIR = 8;
    localparam logic [ADDR_W-1:0] OFS_REF_CTL = 10'h209;
    localparam int NUM_GROUP = 8;
    localparam logic [ADDR_W-1:0] OFS_INTEG = 10'h219;
    localparam int NUM_INTEG = 4;
    localparam logic [ADDR_W-1:0] OFS_XRAM_CTL = 10'h280;
    localparam logic [ADDR_W-1:0] OFS_DELAY_MASK = 10'h283;
    localparam logic [ADDR_W-1:0] OFS_XRAM_DATA = 10'h284;
    localparam int NUM_LINK = 16;
    // Link pair fields.
    localparam int LP_HI_EN = 12;
    localparam int LP_HI_GRP = 8;
    localparam int LP_LO_EN = 4;
    localparam int LP_LO_GRP = 0;
    localparam int GRP_W = 3;
    // Reference link control fields.
    localparam int REF_AUTO = 4;
    localparam int REF_LINK = 0;
    localparam int REF_LINK_W = 4;
    // Integration fields and period base.
    localparam int INT_HI = 8;
    localparam int INT_LO = 0;
    localparam int INT_W = 4;
    localparam int INT_BASE_EXP = 8;
    localparam logic [3:0] INT_CODE_RSVD = 4'hf;
    localparam logic [3:0] INT_CODE_MAX = 4'he;
    localparam int INT_CNT_W = 23;
    // External RAM access control fields and reset value.
    localparam int XC_READY = 7;
    localparam int XC_TOGGLE = 6;
    localparam int XC_DIR = 5;
    localparam int XC_OP_HI = 1;
    localparam int XC_OP_LO = 0;
    localparam logic [15:0] XC_RESET = 16'h0080;
    localparam int XDATA_W = 8;
    // Read turnaround of the external RAM: access cycle plus the pin synchroniser.
    localparam int XRAM_RD_WAIT = 3;

    // One register port request.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } rrc_bus_req_t;

    // External RAM strobe group.
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic data_oe_n;
    } rrc_xram_ctl_t;

    typedef enum logic [2:0] {
        XS_IDLE,
        XS_INIT,
        XS_WRITE,
        XS_READ,
        XS_DONE
    } rrc_xstate_t;
endpackage

// ==== design/rrc_config.sv ====
/*
 * Receive recombiner configuration bank: link to group mapping, link enables with
 * delayed recombination, reference link choice, timing recovery integration periods
 * and the external receive RAM access controller.
 * Assumes a register master on clk_sys, link cell flags from clk_sys logic and an
 * asynchronous external RAM whose read data pins are synchronised here.
 */
// How it works
// RULE1 - Each link pair register serves link N and link N+8; eight registers.
// RULE2 - Bits 10:8 pick the group of upper link N+8.
// RULE3 - Bits 2:0 pick the group of lower link N.
// RULE4 - Bit 4 enables lower link in recombiner, with delayed-recombination setting.
// RULE5 - Bit 12 enables upper link the same way.
// RULE6 - Reference control bit 4 set selects reference link automatically.
// RULE7 - With bit 4 clear, bits 3:0 name the group reference link.
// RULE8 - Reference control bits 8:5 are read-only reserved.
// RULE9 - Integration register holds group n in 3:0, group n+4 in 11:8.
// RULE10 - Integration period is two to the eight plus code clock cycles.
// RULE11 - Software avoids code 1111; prefers 1100 for E1, 1011 for T1.
// RULE12 - Writing access control clears ready; completion sets it again.
// RULE13 - Toggle bit inverts on every rising edge of ready.
// RULE14 - Direction bit 5: zero registers to RAM, one RAM to registers.
// RULE15 - Operation bit 1 set means no external RAM action.
// RULE16 - Operation bits both zero initialise the external RAM.
// RULE17 - Operation 01 does one RAM read or write per direction bit.
// RULE18 - Access control resets with ready set, other bits zero.
// RULE19 - Data register holds transfer byte; software sets address first.
// RULE20 - Delayed link joins recombiner only after first user cell.
// RULE21 - Software waits for ready before starting another RAM operation.
// RULE22 - Unused bits read zero and ignore writes.
`timescale 1ns/1ns
module rrc_config
#(
    parameter int XRAM_AW = 12,
    parameter int XRAM_DEPTH = 4096
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input rrc_pkg::rrc_bus_req_t bus_req,
    output logic [15:0] bus_rdata,
    input wire logic [rrc_pkg::NUM_LINK-1:0] user_cell_seen,
    output logic [rrc_pkg::NUM_LINK-1:0] link_in_recomb,
    output logic [rrc_pkg::NUM_LINK*rrc_pkg::GRP_W-1:0] link_group,
    output logic [rrc_pkg::NUM_GROUP-1:0] ref_auto,
    output logic [rrc_pkg::NUM_GROUP*rrc_pkg::REF_LINK_W-1:0] ref_link,
    output logic [rrc_pkg::NUM_GROUP-1:0] integ_tick,
    input wire logic [XRAM_AW-1:0] xram_addr_sel,
    output logic [XRAM_AW-1:0] xram_addr,
    output logic [rrc_pkg::XDATA_W-1:0] xram_data_o,
    input wire logic [rrc_pkg::XDATA_W-1:0] xram_data_i,
    output rrc_pkg::rrc_xram_ctl_t xram_ctl
);
    import rrc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Address decoding.
    // True when the address falls inside a block of consecutive registers.
    function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
                                      input int n);
        in_range = (a >= base) && (a < base + ADDR_W'(n));
    endfunction

    logic [ADDR_W-1:0] a;
    logic hit_pair, hit_ref, hit_integ, hit_xctl, hit_dmask, hit_xdata;
    logic [2:0] idx_pair;
    logic [2:0] idx_ref;
    logic [1:0] idx_integ;

    // Decode of the current request address into register hits and indices.
    assign a = bus_req.addr;
    // RULE1 eight pair registers
    assign hit_pair = in_range(a, OFS_LINK_PAIR, NUM_LINK_PAIR);
    assign hit_ref = in_range(a, OFS_REF_CTL, NUM_GROUP);
    assign hit_integ = in_range(a, OFS_INTEG, NUM_INTEG);
    assign hit_xctl = (a == OFS_XRAM_CTL);
    assign hit_dmask = (a == OFS_DELAY_MASK);
    assign hit_xdata = (a == OFS_XRAM_DATA);
    assign idx_pair = 3'(a - OFS_LINK_PAIR);
    assign idx_ref = 3'(a - OFS_REF_CTL);
    assign idx_integ = 2'(a - OFS_INTEG);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    logic [15:0] pair_reg [NUM_LINK_PAIR];
    logic [4:0] ref_reg [NUM_GROUP];
    logic [15:0] integ_reg [NUM_INTEG];
    logic [NUM_LINK-1:0] dmask_reg;
    logic [15:0] pair_wmask;
    logic [15:0] integ_wmask;

    // Only documented fields take write data; the rest stay zero.
    // RULE22 unused bits ignored
    assign pair_wmask = 16'h1717;
    assign integ_wmask = 16'h0f0f;

    // Storage for link pairs, reference control, integration and delay mask.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pair_reg <= '{default: 16'h0000};
            ref_reg <= '{default: 5'h00};
            integ_reg <= '{default: 16'h0000};
            dmask_reg <= 16'h0000;
        end
        else if (ce && bus_req.wr)
        begin
            if (hit_pair)
                pair_reg[idx_pair] <= bus_req.wdata & pair_wmask;
            else if (hit_ref)
                ref_reg[idx_ref] <= bus_req.wdata[4:0];
            else if (hit_integ)
                integ_reg[idx_integ] <= bus_req.wdata & integ_wmask;
            else if (hit_dmask)
                dmask_reg <= bus_req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-link and per-group outputs.

    logic [NUM_LINK-1:0] link_en;
    logic [NUM_LINK-1:0] seen_reg;
    logic [3:0] integ_code [NUM_GROUP];
    logic [INT_CNT_W-1:0] integ_cnt [NUM_GROUP];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINK_PAIR; gi++)
        begin : g_pair
            // RULE3 lower link group
            assign link_group[gi*GRP_W +: GRP_W] = pair_reg[gi][LP_LO_GRP +: GRP_W];
            // RULE2 upper link group
            assign link_group[(gi+8)*GRP_W +: GRP_W] = pair_reg[gi][LP_HI_GRP +: GRP_W];
            // RULE4 lower link enable
            assign link_en[gi] = pair_reg[gi][LP_LO_EN];
            // RULE5 upper link enable
            assign link_en[gi+8] = pair_reg[gi][LP_HI_EN];
        end
        for (gi = 0; gi < NUM_GROUP; gi++)
        begin : g_group
            // RULE6 automatic reference select
            assign ref_auto[gi] = ref_reg[gi][REF_AUTO];
            // RULE7 fixed reference link
            assign ref_link[gi*REF_LINK_W +: REF_LINK_W] = ref_reg[gi][REF_LINK +: REF_LINK_W];
            // RULE9 group n low nibble, n+4 high nibble
            assign integ_code[gi] = (gi < NUM_INTEG) ? integ_reg[gi % NUM_INTEG][INT_LO +: INT_W]
                                                    : integ_reg[gi % NUM_INTEG][INT_HI +: INT_W];
            // RULE10 period counter
            // The reserved code is clamped to the longest period so the counter never wraps.
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                begin
                    integ_cnt[gi] <= '0;
                    integ_tick[gi] <= 1'b0;
                end
                else if (ce)
                begin
                    integ_tick[gi] <= (integ_cnt[gi] == INT_CNT_W'(0));
                    if (integ_cnt[gi] == INT_CNT_W'(0))
                        integ_cnt[gi] <= INT_CNT_W'((1 << (INT_BASE_EXP +
                            ((integ_code[gi] == INT_CODE_RSVD) ? INT_CODE_MAX : integ_code[gi])))
                            - 1);
                    else
                        integ_cnt[gi] <= integ_cnt[gi] - INT_CNT_W'(1);
                end
            end
        end
    endgenerate

    // Remember the first user cell of each enabled link; a disable forgets it.
    // RULE20 wait for first cell
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            seen_reg <= 16'h0000;
            link_in_recomb <= 16'h0000;
        end
        else if (ce)
        begin
            seen_reg <= link_en & (seen_reg | user_cell_seen);
            link_in_recomb <= link_en & (~dmask_reg | seen_reg | user_cell_seen);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External RAM access controller.

    rrc_xstate_t xstate_reg;
    logic ready_reg;
    logic toggle_reg;
    logic dir_reg;
    logic [1:0] op_reg;
    logic [XDATA_W-1:0] xdata_reg;
    logic [XRAM_AW-1:0] init_addr_reg;
    logic [1:0] wait_reg;
    logic [XDATA_W-1:0] din_s1_reg;
    logic [XDATA_W-1:0] din_s2_reg;
    logic ctl_wr;
    logic ready_next;

    assign ctl_wr = ce && bus_req.wr && hit_xctl;
    // RULE12 ready low while busy
    // Completion beats a same-cycle write, which is ignored, so ready cannot stick low.
    assign ready_next = (xstate_reg == XS_DONE) ? 1'b1 : (ctl_wr ? 1'b0 : ready_reg);
    // Read data pins pass two flip-flops before use.
    always_ff @(posedge clk_sys)
    begin
        if (ce)
        begin
            din_s1_reg <= xram_data_i;
            din_s2_reg <= din_s1_reg;
        end
    end

    // Transfer sequencer, control fields, ready, toggle and data byte.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            // RULE18 reset value
            xstate_reg <= XS_IDLE;
            ready_reg <= XC_RESET[XC_READY];
            toggle_reg <= XC_RESET[XC_TOGGLE];
            dir_reg <= 1'b0;
            op_reg <= 2'b00;
            xdata_reg <= 8'h00;
            init_addr_reg <= '0;
            wait_reg <= 2'h0;
        end
        else if (ce)
        begin
            ready_reg <= ready_next;
            // RULE13 toggle on ready rise
            if (ready_next && !ready_reg)
                toggle_reg <= ~toggle_reg;
            if (bus_req.wr && hit_xdata)
                xdata_reg <= bus_req.wdata[XDATA_W-1:0];
            case (xstate_reg)
                XS_IDLE:
                begin
                    if (ctl_wr)
                    begin
                        dir_reg <= bus_req.wdata[XC_DIR];
                        op_reg <= bus_req.wdata[XC_OP_HI:XC_OP_LO];
                        init_addr_reg <= '0;
                        wait_reg <= 2'(XRAM_RD_WAIT - 1);
                        // RULE15 no access
                        if (bus_req.wdata[XC_OP_HI])
                            xstate_reg <= XS_DONE;
                        // RULE16 initialise
                        else if (!bus_req.wdata[XC_OP_LO])
                            xstate_reg <= XS_INIT;
                        // RULE14 direction choice
                        else if (bus_req.wdata[XC_DIR])
                            xstate_reg <= XS_READ;
                        else
                            xstate_reg <= XS_WRITE;
                    end
                end
                XS_INIT:
                begin
                    init_addr_reg <= init_addr_reg + XRAM_AW'(1);
                    if (init_addr_reg == XRAM_AW'(XRAM_DEPTH - 1))
                        xstate_reg <= XS_DONE;
                end
                XS_WRITE:
                    xstate_reg <= XS_DONE;
                XS_READ:
                begin
                    // RULE17 single read
                    wait_reg <= wait_reg - 2'h1;
                    if (wait_reg == 2'h0)
                    begin
                        // RULE19 byte from RAM
                        xdata_reg <= din_s2_reg;
                        xstate_reg <= XS_DONE;
                    end
                end
                default:
                    xstate_reg <= XS_IDLE;
            endcase
        end
    end

    // RAM pins: address, data and active-low strobes follow the state.
    // RULE19 software address used
    assign xram_addr = (xstate_reg == XS_INIT) ? init_addr_reg : xram_addr_sel;
    assign xram_data_o = (xstate_reg == XS_INIT) ? 8'h00 : xdata_reg;
    assign xram_ctl.ce_n = !(xstate_reg == XS_INIT || xstate_reg == XS_WRITE ||
                             xstate_reg == XS_READ);
    assign xram_ctl.we_n = !(xstate_reg == XS_INIT || xstate_reg == XS_WRITE);
    assign xram_ctl.data_oe_n = xram_ctl.we_n;

    ////////////////////////////////////////////////////////////////////////////
    // Read port.
    logic [15:0] rd_next;

    // Read selection; unmapped and unused bits answer zero.
    // RULE8 reserved bits read zero
    assign rd_next = hit_pair ? pair_reg[idx_pair] :
        hit_ref ? {11'h000, ref_reg[idx_ref]} :
        hit_integ ? integ_reg[idx_integ] :
        hit_xctl ? {8'h00, ready_reg, toggle_reg, dir_reg, 3'h0, op_reg} :
        hit_dmask ? dmask_reg :
        hit_xdata ? {8'h00, xdata_reg} : 16'h0000;

    // Read data registered one cycle after the strobe.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            bus_rdata <= 16'h0000;
        else if (ce)
            bus_rdata <= bus_req.rd ? rd_next : 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence ctl_write_s;
        ctl_wr && xstate_reg != XS_DONE;
    endsequence
    sequence noop_write_s;
        ctl_wr && bus_req.wdata[XC_OP_HI] && xstate_reg == XS_IDLE;
    endsequence
    ready_clear_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE12
        ctl_write_s |=> !ready_reg)
        else $error("ready not cleared by control write");
    toggle_flip_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE13
        $rose(ready_reg) |-> toggle_reg != $past(toggle_reg))
        else $error("toggle did not flip on ready rise");
    noop_quiet_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE15
        noop_write_s |=> (xram_ctl.ce_n && !ready_reg) ##1 (!$past(ce) || ready_reg))
        else $error("no-access operation touched RAM or stalled");
    init_start_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE16
        (ctl_wr && xstate_reg == XS_IDLE && bus_req.wdata[1:0] == 2'b00) |=>
        (!xram_ctl.we_n && xram_addr == '0 && xram_data_o == 8'h00))
        else $error("initialise did not start at address zero");
    write_one_a: assert property (@(posedge clk_sys) disable iff (rst || !ce) // RULE14
        (ctl_wr && xstate_reg == XS_IDLE && bus_req.wdata[5] == 1'b0 && bus_req.wdata[1:0] == 2'b01)
        |=> !xram_ctl.we_n ##1 (xram_ctl.we_n && xram_ctl.ce_n))
        else $error("single write not one strobe");
    read_capture_a: assert property (@(posedge clk_sys) disable iff (rst || !ce) // RULE17
        (xstate_reg == XS_READ && wait_reg == 2'h0) |=>
        (xdata_reg == $past(din_s2_reg) && xram_ctl.we_n))
        else $error("read byte not captured");
    link_map_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
        (link_in_recomb[0] |-> $past(link_en[0])) and (link_in_recomb[8] |-> $past(link_en[8])))
        else $error("disabled link placed in recombiner");
    delay_wait_a: assert property (@(posedge clk_sys) disable iff (rst || !ce) // RULE20
        ($past(dmask_reg[0]) && !$past(seen_reg[0]) && !$past(user_cell_seen[0])) |->
        !link_in_recomb[0])
        else $error("delayed link joined before first cell");
    group_field_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
        (ce && bus_req.wr && hit_pair && idx_pair == 3'h0) |=>
        link_group[8*GRP_W +: GRP_W] == $past(bus_req.wdata[LP_HI_GRP +: GRP_W]))
        else $error("upper link group field misplaced");
    reset_value_a: assert property (@(posedge clk_sys) // RULE18
        ($past(rst) && !rst) |-> (ready_reg && !dir_reg && op_reg == 2'b00))
        else $error("control reset value wrong");

endmodule // rrc_config

// ==== dv/rrc_sram_model.sv ====
/*
 * Behavioural external receive RAM that sits on the far side of the access sequencer.
 * Assumes active-low strobes from the bank and an asynchronous read path.
 */
`timescale 1ns/1ns
module rrc_sram_model
#(
    parameter int AW = 4,
    parameter int RD_DLY = 30
)
(
    input wire logic clk_sys,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    input rrc_pkg::rrc_xram_ctl_t ctl,
    output logic [7:0] rdata
);
    import rrc_pkg::*;
    logic [7:0] mem [2**AW];
    logic [7:0] last = 8'h00;
    wire rd_sel = !ctl.ce_n && ctl.we_n;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Stores the byte on an edge with both strobes low, and remembers the last byte read.
    always @(posedge clk_sys)
    begin
        if (!ctl.ce_n && !ctl.we_n)
            mem[addr] <= wdata;
        if (rd_sel)
            last <= mem[addr];
    end

    // A deselected RAM shows the inverse of its last byte, so stale data cannot pass.
    assign #(RD_DLY) rdata = rd_sel ? mem[addr] : ~last;
endmodule // rrc_sram_model

// ==== dv/test_rx_recombiner_config.sv ====
/*
 * Self-checking bench for the receive recombiner configuration bank.
 * Assumes rrc_pkg, rrc_config and the external RAM model are compiled first.
 */
`timescale 1ns/1ns
module test_rx_recombiner_config;
    import rrc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    rrc_bus_req_t bus_req = '0;
    logic [15:0] bus_rdata;
    logic [15:0] user_cell_seen = 16'h0000;
    logic [15:0] link_in_recomb;
    logic [47:0] link_group;
    logic [7:0] ref_auto;
    logic [7:0] integ_tick;
    logic [31:0] ref_link;
    logic [3:0] xram_addr_sel = 4'h0;
    logic [3:0] xram_addr;
    logic [7:0] xram_data_o;
    logic [7:0] xram_data_i;
    rrc_xram_ctl_t xram_ctl;
    int fails = 0;
    int n_compared = 0;
    logic [31:0] lfsr = 32'hd96e9093;
    logic tgl = 1'b0;
    logic ram_act = 1'b0;
    int mem_m [16];

    // Clock at 10 MHz.
    always #50 clk_sys = ~clk_sys;

    rrc_config #(.XRAM_AW(4), .XRAM_DEPTH(16)) uut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .user_cell_seen(user_cell_seen),
        .link_in_recomb(link_in_recomb), .link_group(link_group), .ref_auto(ref_auto),
        .ref_link(ref_link), .integ_tick(integ_tick), .xram_addr_sel(xram_addr_sel),
        .xram_addr(xram_addr), .xram_data_o(xram_data_o), .xram_data_i(xram_data_i),
        .xram_ctl(xram_ctl));

    rrc_sram_model #(.AW(4), .RD_DLY(30)) ram (.clk_sys(clk_sys), .addr(xram_addr),
        .wdata(xram_data_o), .ctl(xram_ctl), .rdata(xram_data_i));

    // Notes any RAM selection, so a no-action request can be seen to stay off the pins.
    always @(posedge clk_sys)
        if (xram_ctl.ce_n === 1'b0)
            ram_act <= 1'b1;

    ////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One-cycle register write; the strobe drops after the edge that takes it.
    task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_req <= {a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask

    // One-cycle register read; data is taken in the cycle after the strobe.
    task automatic rd_reg(input logic [9:0] a, output logic [15:0] v);
        @(posedge clk_sys);
        bus_req <= {a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1 v = bus_rdata;
    endtask

    // Starts a RAM operation, polls ready under a bound and checks the final status word.
    task automatic xop(input logic [15:0] c);
        int i;
        logic [15:0] v;
        wr_reg(OFS_XRAM_CTL, c);
        rd_reg(OFS_XRAM_CTL, v);
        if (!c[1])
            chk(v[7], 1'b0);
        for (i = 0; i < 40 && v[7] !== 1'b1; i++)
            rd_reg(OFS_XRAM_CTL, v);
        tgl = !tgl;
        chk(v, {8'h00, 1'b1, tgl, c[5], 3'b000, c[1:0]});
    endtask

    // Counts the cycles between two consecutive ticks of one group.
    task automatic tick_gap(input int g, output int n);
        int k;
        n = 0;
        for (k = 0; k < 3000 && integ_tick[g] !== 1'b1; k++)
            @(posedge clk_sys);
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (integ_tick[g] !== 1'b1 && n < 3000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, register map, periods, link admission, then RAM transfers.
    initial
    begin
        logic [15:0] d;
        logic [15:0] v;
        int i;
        int n;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd_reg(OFS_XRAM_CTL, v);
        chk(v, XC_RESET);
        for (i = 0; i < NUM_LINK_PAIR; i++)
        begin
            lfsr = next_rand(lfsr);
            d = lfsr[15:0];
            wr_reg(10'(OFS_LINK_PAIR + i), d);
            rd_reg(10'(OFS_LINK_PAIR + i), v);
            chk(v, d & 16'h1717);
            chk(link_group[3*i +: 3], d[2:0]);
            chk(link_group[3*(i+8) +: 3], d[10:8]);
            lfsr = next_rand(lfsr);
            d = lfsr[15:0];
            wr_reg(10'(OFS_REF_CTL + i), d);
            rd_reg(10'(OFS_REF_CTL + i), v);
            chk(v, d & 16'h001f);
            chk(ref_auto[i], d[4]);
            chk(ref_link[4*i +: 4], d[3:0]);
        end
        for (i = 0; i < NUM_INTEG; i++)
        begin
            lfsr = next_rand(lfsr);
            d = lfsr[15:0] & 16'h0f0f;
            if (d[3:0] == 4'hf) d[3:0] = 4'he;
            if (d[11:8] == 4'hf) d[11:8] = 4'he;
            wr_reg(10'(OFS_INTEG + i), d);
            rd_reg(10'(OFS_INTEG + i), v);
            chk(v, d);
        end
        wr_reg(10'h211, 16'hffff);
        rd_reg(10'h211, v);
        chk(v, 16'h0000);
        wr_reg(OFS_INTEG, 16'h0100);
        tick_gap(0, n);
        chk(n, 1 << INT_BASE_EXP);
        tick_gap(4, n);
        chk(n, 1 << (INT_BASE_EXP + 1));
        wr_reg(OFS_DELAY_MASK, 16'h0001);
        wr_reg(OFS_LINK_PAIR, 16'h1010);
        repeat (3) @(posedge clk_sys);
        #1 chk(link_in_recomb[0], 1'b0);
        chk(link_in_recomb[8], 1'b1);
        user_cell_seen <= 16'h0001;
        @(posedge clk_sys);
        user_cell_seen <= 16'h0000;
        repeat (3) @(posedge clk_sys);
        #1 chk(link_in_recomb[0], 1'b1);
        wr_reg(OFS_LINK_PAIR, 16'h0000);
        repeat (3) @(posedge clk_sys);
        #1 chk({link_in_recomb[8], link_in_recomb[0]}, 2'b00);
        // A write taken while the clock enable is low must leave the bank untouched.
        ce <= 1'b0;
        wr_reg(OFS_LINK_PAIR, 16'h1010);
        ce <= 1'b1;
        rd_reg(OFS_LINK_PAIR, v);
        chk(v, 16'h0000);
        chk(link_in_recomb[8], 1'b0);
        xram_addr_sel <= 4'h5;
        wr_reg(OFS_XRAM_DATA, 16'h00a5);
        xop(16'h0001);
        mem_m[5] = 8'ha5;
        xram_addr_sel <= 4'h6;
        wr_reg(OFS_XRAM_DATA, 16'h003c);
        xop(16'h0001);
        mem_m[6] = 8'h3c;
        xram_addr_sel <= 4'h5;
        wr_reg(OFS_XRAM_DATA, 16'h0000);
        xop(16'h0021);
        rd_reg(OFS_XRAM_DATA, v);
        chk(v, mem_m[5]);
        ram_act = 1'b0;
        xop(16'h0022);
        chk(ram_act, 1'b0);
        rd_reg(OFS_XRAM_DATA, v);
        chk(v, mem_m[5]);
        xop(16'h0000);
        foreach (mem_m[k]) mem_m[k] = 0;
        xram_addr_sel <= 4'h6;
        xop(16'h0021);
        rd_reg(OFS_XRAM_DATA, v);
        chk(v, mem_m[6]);
        results;
    end

    // Watchdog well beyond the expected run of about 1400 cycles.
    initial
    begin
        repeat (30000) @(posedge clk_sys);
        fails++;
        results;
    end
endmodule // test_rx_recombiner_config
